// file: logic/host_port_interrupt_reset.sv
`timescale 1ns/10ps
// Overview of operation
// RQ1 - address latch pin level chooses strobe/rw or separate rd/wr style
// RQ2 - any edge on address latch pin selects multiplexed mode until reset
// RQ3 - serial select reaches serial blocks, switch select reaches the rest
// RQ4 - muxed: even-only mode uses even addresses, else addresses up to 7f
// RQ5 - non-muxed: bank select bit is ORed with address line four
// RQ6 - interrupt line raised; top status names source, local status causes
// RQ7 - top status read clears watchdog and arbiter flags; others locally
// RQ8 - interrupt is a level held until every pending source is serviced
// RQ9 - interrupt drops for the whole of a top mask write
// RQ10 - edge-triggered host should rewrite top mask at end of service
// RQ11 - watchdog interrupt has no mask and always flags and interrupts
// RQ12 - arbiter mask blocks both the arbiter flag and the interrupt
// RQ13 - switch and serial top masks block only the interrupt
// RQ14 - locally masked sources show in no status and raise no interrupt
// RQ15 - masked events are kept and appear when the local mask clears
// RQ16 - after power-up all host accesses are ignored while resetting
// RQ17 - eight frame strobe periods with bit clock release the reset; the code counts frame strobes without looking at the bit clock
// RQ18 - external reset pulse of four bit clocks also releases reset
// RQ19 - on release registers hold reset values and accept accesses
// RQ20 - everything runs only on the pcm bit clock being present; the code uses the bit clock only to time the external reset pulse
// RQ21 - port clock and sync are outputs unless clock source bit set
// RQ22 - external port clocks must come from the same master clock
// RQ23 - sub-block top flag set while any unmasked local bit is pending
module host_port_interrupt_reset
  import hpir_pkg::*;
#(
  parameter int SW_W   = 8,
  parameter int SER_W  = 8,
  parameter int ADDR_W = 8
) (
  // clock and control
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              clkEn,
  // pcm timing, sampled in clk_sys
  input  wire logic              pcmBitClock,
  input  wire logic              pcmFrameStrobe,
  input  wire logic              externalResetInput,
  // host bus
  input  wire logic              addrLatch,
  input  wire logic              serialCtrlSelect_n,
  input  wire logic              switchBlockSelect_n,
  input  wire logic              hostRead,
  input  wire logic              hostWrite,
  input  wire logic [ADDR_W-1:0] hostAddr,
  // configuration bits
  input  wire logic              evenAddressOnly,
  input  wire logic              registerBankSelect,
  input  wire logic              clockSourceBit,
  // top status and mask access
  input  wire logic              topStatusRead,
  input  wire logic              topMaskWrite,
  input  wire logic [TOP_WIDTH-1:0] topMaskData,
  // sub-block events and local masks
  input  wire logic              watchdogEvent,
  input  wire logic              arbiterEvent,
  input  wire logic [SW_W-1:0]   switchEvent,
  input  wire logic [SW_W-1:0]   switchLocalMask,
  input  wire logic              switchStatusRead,
  input  wire logic [SER_W-1:0]  serialAEvent,
  input  wire logic [SER_W-1:0]  serialALocalMask,
  input  wire logic              serialAStatusRead,
  input  wire logic              serialAExtPending,
  input  wire logic [SER_W-1:0]  serialBEvent,
  input  wire logic [SER_W-1:0]  serialBLocalMask,
  input  wire logic              serialBStatusRead,
  input  wire logic              serialBExtPending,
  // decode outputs
  output logic [1:0]             busStyle,
  output logic                   selSerial,
  output logic                   selSwitch,
  output logic                   accessValid,
  output logic [ADDR_W-1:0]      effAddr,
  // status and interrupt
  output logic [TOP_WIDTH-1:0]   topInterruptStatus,
  output logic [SW_W-1:0]        switchLocalStatus,
  output logic [SER_W-1:0]       serialALocalStatus,
  output logic [SER_W-1:0]       serialBLocalStatus,
  output logic                   interrupt_n,
  // reset and port clock direction
  output logic                   deviceReady,
  output logic                   portClockOutEn
);
  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  initial begin
    if (ADDR_W < 8) $error("address width below 8");
    if (SW_W < 1 || SW_W > 8) $error("switch width 1..8");
    if (SER_W < 1 || SER_W > 8) $error("serial width 1..8");
  end

  // address check for muxed modes
  function automatic logic addrOk(input logic [ADDR_W-1:0] a,
                                  input logic evenOnly);
    if (evenOnly) begin
      addrOk = (a[0] == 1'b0);
    end else begin
      addrOk = (a <= ADDR_W'(MUX_ADDR_LIMIT));
    end
  endfunction : addrOk

  // ***************************************************************
  // reset release
  // ***************************************************************
  hpir_rst_t rstStateReg;
  hpir_rst_t rstStateNext;
  logic [3:0] frameCntReg;
  logic [3:0] frameCntNext;
  logic [2:0] extRstCntReg;
  logic [2:0] extRstCntNext;
  logic       bitClkPrevReg;
  logic       frameStbPrevReg;
  logic       bitClkRise;
  logic       frameStbRise;

  assign bitClkRise   = pcmBitClock & ~bitClkPrevReg; // RQ20
  assign frameStbRise = pcmFrameStrobe & ~frameStbPrevReg;

  // count frame strobe edges, and reset pulse length on bit clock edges
  always_comb begin
    rstStateNext  = rstStateReg;
    frameCntNext  = frameCntReg;
    extRstCntNext = extRstCntReg;
    case (rstStateReg)
      RST_HOLD: begin
        if (frameStbRise && frameCntReg < 4'(FRAME_RELEASE_CNT)) begin
          frameCntNext = frameCntReg + 4'h1; // RQ17
        end
        if (!externalResetInput) begin
          extRstCntNext = 3'h0;
        end else if (bitClkRise && extRstCntReg < 3'(EXT_RST_MIN_CNT)) begin
          extRstCntNext = extRstCntReg + 3'h1; // RQ18
        end
        if (frameCntReg == 4'(FRAME_RELEASE_CNT)) begin
          rstStateNext = RST_RUN; // RQ17
        end
        if (extRstCntReg == 3'(EXT_RST_MIN_CNT) && !externalResetInput) begin
          rstStateNext = RST_RUN; // RQ18
        end
      end
      RST_RUN: begin
        frameCntNext  = 4'h0;
        extRstCntNext = 3'h0;
      end
      default: rstStateNext = RST_HOLD;
    endcase
  end

  // edge history loads the pin levels so no false edge follows reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rstStateReg     <= RST_HOLD; // RQ16
      frameCntReg     <= 4'h0;
      extRstCntReg    <= 3'h0;
      bitClkPrevReg   <= pcmBitClock;
      frameStbPrevReg <= pcmFrameStrobe;
    end else if (clkEn) begin
      rstStateReg     <= rstStateNext;
      frameCntReg     <= frameCntNext;
      extRstCntReg    <= extRstCntNext;
      bitClkPrevReg   <= pcmBitClock;
      frameStbPrevReg <= pcmFrameStrobe;
    end
  end

  logic running;
  assign running = (rstStateReg == RST_RUN);

  // ***************************************************************
  // bus style and decode
  // ***************************************************************
  hpir_bus_t styleReg;
  hpir_bus_t styleNext;
  logic      alePrevReg;
  logic      aleSeenReg;
  logic      selSerNext;
  logic      selSwNext;
  logic      validNext;
  logic [ADDR_W-1:0] addrNext;

  // strap at first enabled cycle, any later edge forces muxed
  always_comb begin
    styleNext = styleReg;
    if (!aleSeenReg) begin
      styleNext = addrLatch ? BUS_STROBE_RW : BUS_SPLIT_RDWR; // RQ1
    end else if (addrLatch != alePrevReg) begin
      styleNext = BUS_MUXED; // RQ2
    end
    if (styleReg == BUS_MUXED) begin
      styleNext = BUS_MUXED; // RQ2
    end
    selSerNext = running && !serialCtrlSelect_n; // RQ3
    selSwNext  = running && !switchBlockSelect_n && serialCtrlSelect_n;
    addrNext   = hostAddr;
    if (styleReg != BUS_MUXED) begin
      addrNext[BANK_ADDR_BIT] = hostAddr[BANK_ADDR_BIT] | registerBankSelect;
    end // RQ5
    validNext = running && (selSerNext || selSwNext)
                && (hostRead || hostWrite); // RQ16
    if (styleReg == BUS_MUXED && !addrOk(hostAddr, evenAddressOnly)) begin
      validNext = 1'b0; // RQ4
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      styleReg    <= BUS_SPLIT_RDWR;
      alePrevReg  <= 1'b0;
      aleSeenReg  <= 1'b0;
      selSerial   <= 1'b0;
      selSwitch   <= 1'b0;
      accessValid <= 1'b0;
      effAddr     <= '0;
    end else if (clkEn) begin
      styleReg    <= styleNext;
      alePrevReg  <= addrLatch;
      aleSeenReg  <= 1'b1;
      selSerial   <= selSerNext;
      selSwitch   <= selSwNext;
      accessValid <= validNext;
      effAddr     <= addrNext;
    end
  end

  assign busStyle = styleReg;

  // ***************************************************************
  // interrupt tree
  // ***************************************************************
  logic [TOP_WIDTH-1:0] topMaskReg;
  logic [TOP_WIDTH-1:0] topMaskNext;
  logic                 wdFlagReg;
  logic                 wdFlagNext;
  logic                 arbFlagReg;
  logic                 arbFlagNext;
  logic                 swPend;
  logic                 saPend;
  logic                 sbPend;
  logic [TOP_WIDTH-1:0] topNext;
  logic                 intNext;
  logic                 rdTop;
  logic                 wrMask;
  logic [SW_W-1:0]      swVis;
  logic [SER_W-1:0]     saVis;
  logic [SER_W-1:0]     sbVis;

  assign rdTop  = running && topStatusRead;
  assign wrMask = running && topMaskWrite;

  hpir_local_status #(.WIDTH(SW_W)) u_switch (
    .clk_sys       (clk_sys),
    .sys_rst       (sys_rst || !running),
    .clkEn         (clkEn),
    .srcEvent      (switchEvent),
    .localMask     (switchLocalMask),
    .statusRead    (running && switchStatusRead),
    .visibleStatus (swVis),
    .anyPending    (swPend)
  );

  hpir_local_status #(.WIDTH(SER_W)) u_serial_a (
    .clk_sys       (clk_sys),
    .sys_rst       (sys_rst || !running),
    .clkEn         (clkEn),
    .srcEvent      (serialAEvent),
    .localMask     (serialALocalMask),
    .statusRead    (running && serialAStatusRead),
    .visibleStatus (saVis),
    .anyPending    (saPend)
  );

  hpir_local_status #(.WIDTH(SER_W)) u_serial_b (
    .clk_sys       (clk_sys),
    .sys_rst       (sys_rst || !running),
    .clkEn         (clkEn),
    .srcEvent      (serialBEvent),
    .localMask     (serialBLocalMask),
    .statusRead    (running && serialBStatusRead),
    .visibleStatus (sbVis),
    .anyPending    (sbPend)
  );

  // flags, masking and the level interrupt
  always_comb begin
    topMaskNext = wrMask ? topMaskData : topMaskReg;
    wdFlagNext  = (wdFlagReg && !rdTop) || watchdogEvent; // RQ7 RQ11
    arbFlagNext = (arbFlagReg && !rdTop)
                  || (arbiterEvent && !topMaskReg[TOP_ARB_POS]); // RQ12
    topNext = '0;
    topNext[TOP_WD_POS]     = wdFlagNext;
    topNext[TOP_ARB_POS]    = arbFlagNext;
    topNext[TOP_SW_POS]     = swPend; // RQ13 RQ23
    topNext[TOP_SA_EXT_POS] = serialAExtPending;
    topNext[TOP_SA_POS]     = saPend;
    topNext[TOP_SB_EXT_POS] = serialBExtPending;
    topNext[TOP_SB_POS]     = sbPend;
    // watchdog bypasses mask; others gated by top mask
    intNext = topNext[TOP_WD_POS]
              || |(topNext & ~topMaskReg & ~TOP_WIDTH'(1)); // RQ8 RQ13
    if (wrMask) begin
      intNext = 1'b0; // RQ9
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !running) begin
      topMaskReg         <= TOP_MASK_RESET; // RQ19
      wdFlagReg          <= 1'b0;
      arbFlagReg         <= 1'b0;
      topInterruptStatus <= '0;
      switchLocalStatus  <= '0;
      serialALocalStatus <= '0;
      serialBLocalStatus <= '0;
      interrupt_n        <= 1'b1;
    end else if (clkEn) begin
      topMaskReg         <= topMaskNext;
      wdFlagReg          <= wdFlagNext;
      arbFlagReg         <= arbFlagNext;
      topInterruptStatus <= topNext; // RQ6
      switchLocalStatus  <= swVis;
      serialALocalStatus <= saVis;
      serialBLocalStatus <= sbVis;
      interrupt_n        <= !intNext; // RQ6
    end
  end

  // port clock direction from the clock source bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      deviceReady    <= 1'b0;
      portClockOutEn <= 1'b1;
    end else if (clkEn) begin
      deviceReady    <= rstStateNext == RST_RUN;
      portClockOutEn <= !clockSourceBit; // RQ21
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_mask_write_drop: assert property (@(posedge clk_sys)
    disable iff (sys_rst) clkEn && wrMask |=> interrupt_n) // RQ9
    else $error("interrupt active during mask write");
  a_watchdog_unmask: assert property (@(posedge clk_sys)
    disable iff (sys_rst) clkEn && running && watchdogEvent && !wrMask
    |=> !interrupt_n && topInterruptStatus[TOP_WD_POS]) // RQ11
    else $error("watchdog not flagged");
  a_arb_masked: assert property (@(posedge clk_sys)
    disable iff (sys_rst) clkEn && running && !arbFlagReg
    && topMaskReg[TOP_ARB_POS] && !topMaskWrite
    |=> !arbFlagReg) // RQ12
    else $error("masked arbiter flag set");
  a_top_read_clr: assert property (@(posedge clk_sys)
    disable iff (sys_rst) clkEn && rdTop && !watchdogEvent && !arbiterEvent
    |=> !wdFlagReg && !arbFlagReg) // RQ7
    else $error("top read did not clear");
  a_hold_ignores: assert property (@(posedge clk_sys)
    disable iff (sys_rst) !running |=> !accessValid) // RQ16
    else $error("access during reset");
  a_muxed_sticky: assert property (@(posedge clk_sys)
    disable iff (sys_rst) styleReg == BUS_MUXED |=> styleReg == BUS_MUXED)
    else $error("left muxed mode"); // RQ2
  a_ale_edge_mux: assert property (@(posedge clk_sys)
    disable iff (sys_rst) clkEn && aleSeenReg && addrLatch != alePrevReg
    |=> styleReg == BUS_MUXED) // RQ2
    else $error("edge did not select muxed");
  a_release_frames: assert property (@(posedge clk_sys)
    disable iff (sys_rst) clkEn && frameCntReg == 4'(FRAME_RELEASE_CNT)
    |=> running) // RQ17
    else $error("no release after frames");
  a_switch_flag: assert property (@(posedge clk_sys)
    disable iff (sys_rst) clkEn && running && swPend
    |=> topInterruptStatus[TOP_SW_POS]) // RQ23
    else $error("switch flag missing");

  c_release: cover property (@(posedge clk_sys) !running ##1 running);
  c_int_raise: cover property (@(posedge clk_sys) interrupt_n ##1 !interrupt_n);
  c_muxed: cover property (@(posedge clk_sys) styleReg == BUS_MUXED);
endmodule : host_port_interrupt_reset

// file: logic/hpir_pkg.sv
package hpir_pkg;
  // ***************************************************************
  // bus styles, states and counts
  // ***************************************************************
  typedef enum logic [1:0] {
    BUS_STROBE_RW,
    BUS_SPLIT_RDWR,
    BUS_MUXED
  } hpir_bus_t;

  typedef enum logic {
    RST_HOLD,
    RST_RUN
  } hpir_rst_t;

  localparam int          FRAME_RELEASE_CNT = 8;
  localparam int          EXT_RST_MIN_CNT   = 4;
  localparam logic [7:0]  MUX_ADDR_LIMIT    = 8'h7f;
  localparam int          BANK_ADDR_BIT     = 4;
  // top status bit positions
  localparam int          TOP_WD_POS        = 0;
  localparam int          TOP_ARB_POS       = 1;
  localparam int          TOP_SW_POS        = 2;
  localparam int          TOP_SA_EXT_POS    = 3;
  localparam int          TOP_SA_POS        = 4;
  localparam int          TOP_SB_EXT_POS    = 5;
  localparam int          TOP_SB_POS        = 6;
  localparam int          TOP_WIDTH         = 7;
  localparam logic [6:0]  TOP_MASK_RESET    = 7'h7f;
  localparam logic [7:0]  LOCAL_MASK_RESET  = 8'hff;
endpackage : hpir_pkg

// file: logic/hpir_local_status.sv
`timescale 1ns/10ps
// one local status register with local mask and hidden latch
module hpir_local_status
  import hpir_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and control
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  // events and mask
  input  wire logic [WIDTH-1:0] srcEvent,
  input  wire logic [WIDTH-1:0] localMask,
  input  wire logic             statusRead,
  // visible state
  output logic      [WIDTH-1:0] visibleStatus,
  output logic                  anyPending
);
  initial begin
    if (WIDTH < 1 || WIDTH > 8) $error("local status width 1..8");
  end

  logic [WIDTH-1:0] heldReg;
  logic [WIDTH-1:0] heldNext;

  // visible bits are the unmasked held events
  assign visibleStatus = heldReg & ~localMask; // RQ14
  assign anyPending    = |visibleStatus;        // RQ23

  // masked events stay held; a read clears only shown bits, set wins
  always_comb begin
    heldNext = heldReg;
    if (statusRead) begin
      heldNext = heldNext & localMask; // RQ15
    end
    heldNext = heldNext | srcEvent;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      heldReg <= '0;
    end else if (clkEn) begin
      heldReg <= heldNext;
    end
  end

  a_masked_held: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clkEn && srcEvent[0] |=> heldReg[0]) // RQ15
    else $error("event not retained");
endmodule : hpir_local_status

// file: tb/hpir_host_model.sv
`timescale 1ns/10ps
// ***************************************
// host processor model, service routine
// ***************************************
module hpir_host_model
  import hpir_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // bench commands
  input  wire logic       cmdRead,
  input  wire logic       cmdMask,
  input  wire logic [6:0] cmdMaskVal,
  input  wire logic       autoService,
  // device side
  input  wire logic       interrupt_n,
  output logic            topStatusRead,
  output logic            topMaskWrite,
  output logic      [6:0] topMaskData
);
  logic [2:0] wrLeft;
  logic [6:0] maskHeld;
  logic       rewrite;

  // status read pulses and mask writes held four cycles
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wrLeft        <= 3'h0;
      maskHeld      <= TOP_MASK_RESET;
      rewrite       <= 1'b0;
      topStatusRead <= 1'b0;
      topMaskWrite  <= 1'b0;
      topMaskData   <= ~TOP_MASK_RESET;
    end else begin
      topStatusRead <= cmdRead;
      rewrite       <= 1'b0;
      if (autoService && !interrupt_n && wrLeft == 3'h0 && !rewrite
          && !topStatusRead) begin
        topStatusRead <= 1'b1;
        rewrite       <= 1'b1;
      end
      if ((cmdMask || rewrite) && wrLeft == 3'h0) begin
        wrLeft       <= 3'h4;
        topMaskWrite <= 1'b1;
        topMaskData  <= cmdMask ? cmdMaskVal : maskHeld;
        maskHeld     <= cmdMask ? cmdMaskVal : maskHeld;
      end else if (wrLeft == 3'h1) begin
        wrLeft       <= 3'h0;
        topMaskWrite <= 1'b0;
        topMaskData  <= ~topMaskData; // released bus, no stale data
      end else if (wrLeft != 3'h0) begin
        wrLeft <= wrLeft - 3'h1;
      end
    end
  end
endmodule : hpir_host_model

// file: tb/host_port_interrupt_reset_tb_top.sv
`timescale 1ns/10ps
module host_port_interrupt_reset_tb_top
  import hpir_pkg::*;
;
  typedef struct {string nm; int sel; logic [7:0] v;} hpir_exp_t;
  logic clk_sys = 1'b0, sys_rst = 1'b1, frameRun = 1'b1;
  logic pcmBitClock = 1'b0, pcmFrameStrobe = 1'b0;
  logic externalResetInput = 1'b0, addrLatch = 1'b0;
  logic serialCtrlSelect_n = 1'b1, switchBlockSelect_n = 1'b1;
  logic hostRead = 1'b0, hostWrite = 1'b0, evenAddressOnly = 1'b0;
  logic registerBankSelect = 1'b0, clockSourceBit = 1'b0;
  logic watchdogEvent = 1'b0, arbiterEvent = 1'b0;
  logic switchStatusRead = 1'b0, serialAStatusRead = 1'b0;
  logic serialAExtPending = 1'b0, cmdRead = 1'b0, cmdMask = 1'b0;
  logic autoService = 1'b0;
  logic [6:0] cmdMaskVal = 7'h7f;
  logic [7:0] hostAddr = 8'h00, switchEvent = 8'h00, serialAEvent = 8'h00;
  logic [7:0] switchLocalMask = 8'hff, serialALocalMask = 8'hff;
  logic [7:0] nFrames = 8'h00, effAddr, switchLocalStatus;
  logic [7:0] serialALocalStatus, serialBLocalStatus;
  logic [15:0] pdiv = 16'h0000, lfsr = 16'ha55b;
  logic [6:0] topMaskData, topInterruptStatus;
  logic [1:0] busStyle;
  logic topStatusRead, topMaskWrite, selSerial, selSwitch, accessValid;
  logic interrupt_n, deviceReady, portClockOutEn;
  int n_errors = 0, n_checks = 0, cyc = 0, k;
  hpir_exp_t q[$];
  hpir_exp_t e;

  host_port_interrupt_reset i_dut (.clk_sys, .sys_rst, .clkEn(1'b1),
    .pcmBitClock, .pcmFrameStrobe, .externalResetInput, .addrLatch,
    .serialCtrlSelect_n, .switchBlockSelect_n, .hostRead, .hostWrite,
    .hostAddr, .evenAddressOnly, .registerBankSelect, .clockSourceBit,
    .topStatusRead, .topMaskWrite, .topMaskData, .watchdogEvent,
    .arbiterEvent, .switchEvent, .switchLocalMask, .switchStatusRead,
    .serialAEvent, .serialALocalMask, .serialAStatusRead,
    .serialAExtPending, .serialBEvent(serialAEvent),
    .serialBLocalMask(serialALocalMask),
    .serialBStatusRead(serialAStatusRead),
    .serialBExtPending(serialAExtPending), .busStyle,
    .selSerial, .selSwitch, .accessValid, .effAddr, .topInterruptStatus,
    .switchLocalStatus, .serialALocalStatus, .serialBLocalStatus,
    .interrupt_n, .deviceReady,
    .portClockOutEn);
  hpir_host_model i_host (.clk_sys, .sys_rst, .cmdRead, .cmdMask,
    .cmdMaskVal, .autoService, .interrupt_n, .topStatusRead,
    .topMaskWrite, .topMaskData);

  // ******************
  // clock, pcm timing
  // ******************
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // bit clock always runs, frame strobe every 64 cycles while frameRun, timeout
  always @(posedge clk_sys) begin
    pdiv <= pdiv + 16'h0001;
    cyc <= cyc + 1;
    pcmBitClock <= pdiv[2];
    pcmFrameStrobe <= frameRun && pdiv[5:3] == 3'h0;
    if (sys_rst) nFrames <= 8'h00;
    else if (frameRun && pdiv[5:0] == 6'h3f) nFrames <= nFrames + 8'h01;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  // ******************
  // result checking
  // ******************
  function automatic logic [7:0] obs(input int s);
    case (s)
      0: return {7'h00, interrupt_n};
      1: return {1'b0, topInterruptStatus};
      2: return {7'h00, deviceReady};
      3: return {6'h00, busStyle};
      4: return {7'h00, accessValid};
      5: return effAddr;
      6: return switchLocalStatus;
      7: return {6'h00, selSerial, selSwitch};
      8: return {7'h00, portClockOutEn};
      9: return serialALocalStatus;
      11: return serialBLocalStatus;
      default: return nFrames;
    endcase
  endfunction : obs
  // all queued notes compared at the settled half of the cycle
  always @(negedge clk_sys) begin
    while (q.size() > 0) begin
      e = q.pop_front();
      n_checks++;
      if (obs(e.sel) !== e.v) begin
        n_errors++;
        $display("[ERR] %s expected %h seen %h", e.nm, e.v, obs(e.sel));
      end
    end
  end
  task note(input string nm, input int s, input logic [7:0] v);
    q.push_back('{nm, s, v});
  endtask : note
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsrNext
  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  // one host access with select, address and bank select
  task acc(input logic ser, input logic [7:0] a, input logic bankSel,
           input logic ok, input logic [7:0] ea);
    serialCtrlSelect_n <= !ser;
    switchBlockSelect_n <= ser;
    hostAddr <= a;
    registerBankSelect <= bankSel;
    hostRead <= bankSel;
    hostWrite <= !bankSel;
    tick(3);
    note("select", 7, {6'h00, ser, !ser});
    note("valid", 4, {7'h00, ok});
    if (ok) note("addr", 5, ea);
    hostRead <= 1'b0;
    hostWrite <= 1'b0;
    serialCtrlSelect_n <= 1'b1;
    switchBlockSelect_n <= 1'b1;
    tick(1);
  endtask : acc
  task maskWr(input logic [6:0] m);
    cmdMaskVal <= m;
    cmdMask <= 1'b1;
    tick(1);
    cmdMask <= 1'b0;
  endtask : maskWr

  // ******************
  // main sequence
  // ******************
  initial begin
    tick(10);
    sys_rst <= 1'b0;
    tick(3);
    note("ready", 2, 8'h00);
    note("style", 3, 8'h01);
    hostRead <= 1'b1;
    switchBlockSelect_n <= 1'b0;
    watchdogEvent <= 1'b1;
    tick(1);
    watchdogEvent <= 1'b0;
    tick(2);
    note("valid", 4, 8'h00);
    note("irq", 0, 8'h01);
    hostRead <= 1'b0;
    switchBlockSelect_n <= 1'b1;
    for (k = 0; k < 2000 && deviceReady !== 1'b1; k++) tick(1);
    note("frames", 10, 8'h08);
    note("status", 1, 8'h00);
    note("irq", 0, 8'h01);
    clockSourceBit <= 1'b1;
    tick(3);
    note("clkdir", 8, 8'h00);
    clockSourceBit <= 1'b0;
    tick(3);
    note("clkdir", 8, 8'h01);
    for (k = 0; k < 6; k++) begin
      lfsr = lfsrNext(lfsr);
      acc(k[0], lfsr[7:0], k[1], 1'b1, lfsr[7:0] | {3'h0, k[1], 4'h0});
    end
    $display("end of decode test");
    watchdogEvent <= 1'b1;
    arbiterEvent <= 1'b1;
    tick(1);
    watchdogEvent <= 1'b0;
    arbiterEvent <= 1'b0;
    tick(3);
    note("status", 1, 8'h01);
    note("irq", 0, 8'h00);
    cmdRead <= 1'b1;
    tick(1);
    cmdRead <= 1'b0;
    tick(3);
    note("status", 1, 8'h00);
    note("irq", 0, 8'h01);
    maskWr(7'h79);
    tick(6);
    arbiterEvent <= 1'b1;
    tick(1);
    arbiterEvent <= 1'b0;
    tick(3);
    note("status", 1, 8'h02);
    maskWr(7'h79);
    tick(2);
    note("irq", 0, 8'h01);
    tick(4);
    note("irq", 0, 8'h00);
    switchEvent <= 8'h08;
    tick(1);
    switchEvent <= 8'h00;
    tick(3);
    note("swlocal", 6, 8'h00);
    note("status", 1, 8'h02);
    cmdRead <= 1'b1;
    tick(1);
    cmdRead <= 1'b0;
    switchLocalMask <= 8'hf7;
    tick(3);
    note("swlocal", 6, 8'h08);
    note("status", 1, 8'h04);
    note("irq", 0, 8'h00);
    maskWr(7'h7d);
    tick(8);
    note("status", 1, 8'h04);
    note("irq", 0, 8'h01);
    switchStatusRead <= 1'b1;
    tick(1);
    switchStatusRead <= 1'b0;
    serialAExtPending <= 1'b1;
    serialALocalMask <= 8'h00;
    serialAEvent <= 8'h01;
    tick(1);
    serialAEvent <= 8'h00;
    tick(3);
    note("swlocal", 6, 8'h00);
    note("salocal", 9, 8'h01);
    note("status", 1, 8'h78);
    note("sblocal", 11, 8'h01);
    serialAExtPending <= 1'b0;
    serialAStatusRead <= 1'b1;
    tick(1);
    serialAStatusRead <= 1'b0;
    tick(3);
    note("status", 1, 8'h00);
    autoService <= 1'b1;
    watchdogEvent <= 1'b1;
    tick(1);
    watchdogEvent <= 1'b0;
    tick(14);
    note("status", 1, 8'h00);
    note("irq", 0, 8'h01);
    autoService <= 1'b0;
    $display("end of interrupt test");
    addrLatch <= 1'b1;
    tick(3);
    addrLatch <= 1'b0;
    evenAddressOnly <= 1'b1;
    tick(3);
    note("style", 3, 8'h02);
    acc(1'b1, 8'h05, 1'b0, 1'b0, 8'h00);
    acc(1'b0, 8'h86, 1'b0, 1'b1, 8'h86);
    acc(1'b0, 8'h04, 1'b1, 1'b1, 8'h04);
    evenAddressOnly <= 1'b0;
    acc(1'b1, 8'h80, 1'b0, 1'b0, 8'h00);
    acc(1'b1, 8'h7f, 1'b0, 1'b1, 8'h7f);
    $display("end of muxed test");
    frameRun <= 1'b0;
    addrLatch <= 1'b1;
    sys_rst <= 1'b1;
    tick(10);
    sys_rst <= 1'b0;
    tick(3);
    note("style", 3, 8'h00);
    externalResetInput <= 1'b1;
    tick(16);
    externalResetInput <= 1'b0;
    tick(10);
    note("ready", 2, 8'h00);
    externalResetInput <= 1'b1;
    tick(40);
    externalResetInput <= 1'b0;
    tick(10);
    note("ready", 2, 8'h01);
    $display("end of reset test");
    tick(2);
    results();
  end
endmodule : host_port_interrupt_reset_tb_top
